// ===== core/xirq_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - Bit7 mask gates comparator B rising flag
// - Bit6 mask gates comparator B falling flag
// - Bit5 mask gates comparator A rising flag
// - Bit4 mask gates comparator A falling flag
// - Bit2 mask gates converter window compare
// - Bit0 mask gates all serial peripheral requests
// - Bits 3,1 of first pair read zero
// - Second mask bit7 gates crystal valid flag
// - Second mask bits 5..2 gate soft irqs
// - Second mask bit1 gates conversion done
// - Level bits 7..4 rank comparator sources
// - Level bits 2,0 rank window and serial
// - Second level bit7 ranks crystal valid
// - Second level bits 5..2 rank soft irqs
// - Second level bit1 ranks conversion; bit0 zero
// - Global enable off blocks every source
// - High preempts low; fixed order among equals
module xirq_ctrl
    import xirq_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Special-function register port
    input wire logic [ADDR_W-1:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // Global enable and pending flags from peripherals
    input wire logic global_irq_enable,
    input wire logic cmp_b_rise_flag,
    input wire logic cmp_b_fall_flag,
    input wire logic cmp_a_rise_flag,
    input wire logic cmp_a_fall_flag,
    input wire logic conv_window_flag,
    input wire logic serial_periph_flag,
    input wire logic crystal_valid_flag,
    input wire logic conv_done_flag,
    input wire logic [xirq_pkg::XIRQ_NUM_SOFT-1:0] soft_irq_flag,
    // Core arbitration side
    output logic [xirq_pkg::XIRQ_NUM_SRC-1:0] gated_req,
    output logic [xirq_pkg::XIRQ_NUM_SRC-1:0] gated_level,
    output logic irq_valid,
    output logic [xirq_pkg::XIRQ_IDX_W-1:0] irq_index,
    output logic irq_high,
    input wire logic irq_ack,
    input wire logic irq_return
);
    import xirq_pkg::*;

    if (ADDR_W < 8) begin : g_bad_addr
        $error("xirq_ctrl: ADDR_W must be at least 8");
    end

    logic [7:0] enable_a;
    logic [7:0] enable_b;
    logic [7:0] level_a;
    logic [7:0] level_b;
    logic [7:0] next_enable_a;
    logic [7:0] next_enable_b;
    logic [7:0] next_level_a;
    logic [7:0] next_level_b;
    logic [7:0] next_sfr_rdata;
    logic next_sfr_hit;
    logic [7:0] addr8;

    assign addr8 = sfr_addr[7:0];

    // Register file
    always_comb begin
        next_enable_a = enable_a;
        next_enable_b = enable_b;
        next_level_a = level_a;
        next_level_b = level_b;
        next_sfr_rdata = 8'h00_00;
        next_sfr_hit = 1'b0;
        if (sfr_wr) begin
            case (addr8)
                XIRQ_ADDR_ENABLE_A: next_enable_a = sfr_wdata & XIRQ_WMASK_A;
                XIRQ_ADDR_ENABLE_B: next_enable_b = sfr_wdata & XIRQ_WMASK_B;
                XIRQ_ADDR_LEVEL_A: next_level_a = sfr_wdata & XIRQ_WMASK_A;
                XIRQ_ADDR_LEVEL_B: next_level_b = sfr_wdata & XIRQ_WMASK_B;
                default: ;
            endcase
        end
        if (sfr_rd) begin
            next_sfr_hit = 1'b1;
            case (addr8)
                XIRQ_ADDR_ENABLE_A: next_sfr_rdata = enable_a;
                XIRQ_ADDR_ENABLE_B: next_sfr_rdata = enable_b;
                XIRQ_ADDR_LEVEL_A: next_sfr_rdata = level_a;
                XIRQ_ADDR_LEVEL_B: next_sfr_rdata = level_b;
                default: next_sfr_hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enable_a <= XIRQ_RST_ENABLE_A;
            enable_b <= XIRQ_RST_ENABLE_B;
            level_a <= XIRQ_RST_LEVEL_A;
            level_b <= XIRQ_RST_LEVEL_B;
            sfr_rdata <= 8'h00_00;
            sfr_hit <= 1'b0;
        end else begin
            enable_a <= next_enable_a;
            enable_b <= next_enable_b;
            level_a <= next_level_a;
            level_b <= next_level_b;
            sfr_rdata <= next_sfr_rdata;
            sfr_hit <= next_sfr_hit;
        end
    end

    // Per-source flag, mask and level in fixed order
    logic [XIRQ_NUM_SRC-1:0] src_flag;
    logic [XIRQ_NUM_SRC-1:0] src_mask;
    logic [XIRQ_NUM_SRC-1:0] src_level;

    assign src_flag[XIRQ_SRC_SERIAL] = serial_periph_flag;
    assign src_flag[XIRQ_SRC_CONV_WINDOW] = conv_window_flag;
    assign src_flag[XIRQ_SRC_CMP_A_FALL] = cmp_a_fall_flag;
    assign src_flag[XIRQ_SRC_CMP_A_RISE] = cmp_a_rise_flag;
    assign src_flag[XIRQ_SRC_CMP_B_FALL] = cmp_b_fall_flag;
    assign src_flag[XIRQ_SRC_CMP_B_RISE] = cmp_b_rise_flag;
    assign src_flag[XIRQ_SRC_CONV_DONE] = conv_done_flag;
    assign src_flag[XIRQ_SRC_CLOCK_VALID] = crystal_valid_flag;

    assign src_mask[XIRQ_SRC_SERIAL] = enable_a[XIRQ_BIT_SERIAL];
    assign src_mask[XIRQ_SRC_CONV_WINDOW] = enable_a[XIRQ_BIT_CONV_WINDOW];
    assign src_mask[XIRQ_SRC_CMP_A_FALL] = enable_a[XIRQ_BIT_CMP_A_FALL];
    assign src_mask[XIRQ_SRC_CMP_A_RISE] = enable_a[XIRQ_BIT_CMP_A_RISE];
    assign src_mask[XIRQ_SRC_CMP_B_FALL] = enable_a[XIRQ_BIT_CMP_B_FALL];
    assign src_mask[XIRQ_SRC_CMP_B_RISE] = enable_a[XIRQ_BIT_CMP_B_RISE];
    assign src_mask[XIRQ_SRC_CONV_DONE] = enable_b[XIRQ_BIT_CONV_DONE];
    assign src_mask[XIRQ_SRC_CLOCK_VALID] = enable_b[XIRQ_BIT_CLOCK_VALID];

    assign src_level[XIRQ_SRC_SERIAL] = level_a[XIRQ_BIT_SERIAL];
    assign src_level[XIRQ_SRC_CONV_WINDOW] = level_a[XIRQ_BIT_CONV_WINDOW];
    assign src_level[XIRQ_SRC_CMP_A_FALL] = level_a[XIRQ_BIT_CMP_A_FALL];
    assign src_level[XIRQ_SRC_CMP_A_RISE] = level_a[XIRQ_BIT_CMP_A_RISE];
    assign src_level[XIRQ_SRC_CMP_B_FALL] = level_a[XIRQ_BIT_CMP_B_FALL];
    assign src_level[XIRQ_SRC_CMP_B_RISE] = level_a[XIRQ_BIT_CMP_B_RISE];
    assign src_level[XIRQ_SRC_CONV_DONE] = level_b[XIRQ_BIT_CONV_DONE];
    assign src_level[XIRQ_SRC_CLOCK_VALID] = level_b[XIRQ_BIT_CLOCK_VALID];

    for (genvar s = 0; s < XIRQ_NUM_SOFT; s++) begin : g_soft
        assign src_flag[XIRQ_SRC_SOFT0+s] = soft_irq_flag[s];
        assign src_mask[XIRQ_SRC_SOFT0+s] = enable_b[XIRQ_BIT_SOFT0+s];
        assign src_level[XIRQ_SRC_SOFT0+s] = level_b[XIRQ_BIT_SOFT0+s];
    end

    // Service nesting and selection
    xirq_svc_e svc;
    xirq_svc_e next_svc;
    xirq_svc_e svc_after_ret;
    logic [XIRQ_NUM_SRC-1:0] next_gated_req;
    logic [XIRQ_NUM_SRC-1:0] next_gated_level;
    logic next_irq_valid;
    logic [XIRQ_IDX_W-1:0] next_irq_index;
    logic next_irq_high;
    logic allow_low;
    logic allow_high;

    always_comb begin
        // Masked request only while the global enable is on
        next_gated_req = src_flag & src_mask & {XIRQ_NUM_SRC{global_irq_enable}};
        next_gated_level = src_level;
        // Nothing preempts a high routine; low yields to high only
        allow_high = (svc == XIRQ_SVC_NONE) || (svc == XIRQ_SVC_LOW);
        allow_low = (svc == XIRQ_SVC_NONE);
        next_irq_valid = 1'b0;
        next_irq_index = '0;
        next_irq_high = 1'b0;
        // Downward scan so the lowest index is the last to win
        for (int i = XIRQ_NUM_SRC - 1; i >= 0; i--) begin
            if (next_gated_req[i] && src_level[i] && allow_high) begin
                next_irq_valid = 1'b1;
                next_irq_index = XIRQ_IDX_W'(i);
                next_irq_high = 1'b1;
            end
        end
        if (!next_irq_valid) begin
            for (int i = XIRQ_NUM_SRC - 1; i >= 0; i--) begin
                if (next_gated_req[i] && !src_level[i] && allow_low) begin
                    next_irq_valid = 1'b1;
                    next_irq_index = XIRQ_IDX_W'(i);
                end
            end
        end
        // Return is applied before a same-cycle ack
        svc_after_ret = svc;
        if (irq_return) begin
            case (svc)
                XIRQ_SVC_NEST: svc_after_ret = XIRQ_SVC_LOW;
                default: svc_after_ret = XIRQ_SVC_NONE;
            endcase
        end
        next_svc = svc_after_ret;
        if (irq_ack && irq_valid) begin
            case (svc_after_ret)
                XIRQ_SVC_NONE: next_svc = irq_high ? XIRQ_SVC_HIGH : XIRQ_SVC_LOW;
                XIRQ_SVC_LOW: next_svc = irq_high ? XIRQ_SVC_NEST : XIRQ_SVC_LOW;
                default: next_svc = svc_after_ret;
            endcase
            // Offer is stale once taken; hold it off a cycle
            next_irq_valid = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            svc <= XIRQ_SVC_NONE;
            gated_req <= '0;
            gated_level <= '0;
            irq_valid <= 1'b0;
            irq_index <= '0;
            irq_high <= 1'b0;
        end else begin
            svc <= next_svc;
            gated_req <= next_gated_req;
            gated_level <= next_gated_level;
            irq_valid <= next_irq_valid;
            irq_index <= next_irq_index;
            irq_high <= next_irq_high;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_read_a;
        sfr_rd && (addr8 == XIRQ_ADDR_ENABLE_A || addr8 == XIRQ_ADDR_LEVEL_A);
    endsequence
    sequence s_read_b;
        sfr_rd && (addr8 == XIRQ_ADDR_ENABLE_B || addr8 == XIRQ_ADDR_LEVEL_B);
    endsequence

    a_cmp_b_rise: assert property (
        ##1 gated_req[XIRQ_SRC_CMP_B_RISE] ==
        $past(cmp_b_rise_flag && enable_a[7] && global_irq_enable))
        else $error("comparator B rising gate wrong");
    a_cmp_b_fall: assert property (
        (cmp_b_fall_flag && !enable_a[6]) |=> !gated_req[XIRQ_SRC_CMP_B_FALL])
        else $error("comparator B falling not blocked");
    a_cmp_a_rise: assert property (
        (cmp_a_rise_flag && enable_a[5] && global_irq_enable)
        |=> gated_req[XIRQ_SRC_CMP_A_RISE])
        else $error("comparator A rising not forwarded");
    a_cmp_a_fall: assert property (
        ##1 gated_req[XIRQ_SRC_CMP_A_FALL] ==
        $past(cmp_a_fall_flag && enable_a[4] && global_irq_enable))
        else $error("comparator A falling gate wrong");
    a_conv_window_gate: assert property (
        ##1 gated_req[XIRQ_SRC_CONV_WINDOW] ==
        $past(conv_window_flag && enable_a[2] && global_irq_enable))
        else $error("window compare gate wrong");
    a_serial_gate: assert property (
        ##1 gated_req[XIRQ_SRC_SERIAL] ==
        $past(serial_periph_flag && enable_a[0] && global_irq_enable))
        else $error("serial gate wrong");
    a_unused_a_zero: assert property (
        s_read_a |=> (sfr_rdata[3] == 1'b0 && sfr_rdata[1] == 1'b0 && sfr_hit))
        else $error("unused bits of first pair not zero");
    a_clock_valid_gate: assert property (
        ##1 gated_req[XIRQ_SRC_CLOCK_VALID] ==
        $past(crystal_valid_flag && enable_b[7] && global_irq_enable))
        else $error("clock valid gate wrong");
    a_soft_gate: assert property (
        ##1 gated_req[XIRQ_SRC_SOFT0 +: XIRQ_NUM_SOFT] ==
        ($past(soft_irq_flag & enable_b[5:2]) & {4{$past(global_irq_enable)}}))
        else $error("soft interrupt gate wrong");
    a_conv_done_gate: assert property (
        ##1 gated_req[XIRQ_SRC_CONV_DONE] ==
        $past(conv_done_flag && enable_b[1] && global_irq_enable))
        else $error("conversion done gate wrong");
    a_reserved_b_zero: assert property (
        s_read_b |=> (sfr_rdata[6] == 1'b0 && sfr_rdata[0] == 1'b0 && sfr_hit))
        else $error("reserved bits of second pair not zero");
    a_level_first: assert property (
        (sfr_wr && addr8 == XIRQ_ADDR_LEVEL_A) |=> ##1
        gated_level[XIRQ_SRC_CMP_B_RISE] == $past(sfr_wdata[7], 2) &&
        gated_level[XIRQ_SRC_CMP_A_FALL] == $past(sfr_wdata[4], 2) &&
        gated_level[XIRQ_SRC_SERIAL] == $past(sfr_wdata[0], 2))
        else $error("first level register not applied");
    a_level_second: assert property (
        (sfr_wr && addr8 == XIRQ_ADDR_LEVEL_B) |=> ##1
        gated_level[XIRQ_SRC_CLOCK_VALID] == $past(sfr_wdata[7], 2) &&
        gated_level[XIRQ_SRC_SOFT0 +: XIRQ_NUM_SOFT] == $past(sfr_wdata[5:2], 2) &&
        gated_level[XIRQ_SRC_CONV_DONE] == $past(sfr_wdata[1], 2))
        else $error("second level register not applied");
    a_global_off: assert property (
        !global_irq_enable |=> (gated_req == '0 && !irq_valid))
        else $error("request passed with global enable off");
    a_high_no_preempt: assert property (
        (svc == XIRQ_SVC_HIGH || svc == XIRQ_SVC_NEST) |=> !irq_valid)
        else $error("high routine preempted");
    a_low_only_high: assert property (
        (svc == XIRQ_SVC_LOW && !irq_return) |=> (!irq_valid || irq_high))
        else $error("low routine preempted by low request");
    a_offer_matches: assert property (
        irq_valid |-> (gated_req[irq_index] && gated_level[irq_index] == irq_high))
        else $error("offered source not pending or level mismatch");
endmodule : xirq_ctrl

// ===== core/xirq_pkg.sv
package xirq_pkg;
    // Register addresses in the special-function space
    localparam logic [7:0] XIRQ_ADDR_ENABLE_A = 8'h00_E6;
    localparam logic [7:0] XIRQ_ADDR_ENABLE_B = 8'h00_E7;
    localparam logic [7:0] XIRQ_ADDR_LEVEL_A = 8'h00_F6;
    localparam logic [7:0] XIRQ_ADDR_LEVEL_B = 8'h00_F7;

    // Reset values
    localparam logic [7:0] XIRQ_RST_ENABLE_A = 8'h00_00;
    localparam logic [7:0] XIRQ_RST_ENABLE_B = 8'h00_00;
    localparam logic [7:0] XIRQ_RST_LEVEL_A = 8'h00_00;
    localparam logic [7:0] XIRQ_RST_LEVEL_B = 8'h00_00;

    // Writable bits; all others hold zero
    localparam logic [7:0] XIRQ_WMASK_A = 8'h00_F5;
    localparam logic [7:0] XIRQ_WMASK_B = 8'h00_BE;

    // Field positions, shared by enable and level registers of a pair
    localparam int XIRQ_BIT_CMP_B_RISE = 7;
    localparam int XIRQ_BIT_CMP_B_FALL = 6;
    localparam int XIRQ_BIT_CMP_A_RISE = 5;
    localparam int XIRQ_BIT_CMP_A_FALL = 4;
    localparam int XIRQ_BIT_CONV_WINDOW = 2;
    localparam int XIRQ_BIT_SERIAL = 0;
    localparam int XIRQ_BIT_CLOCK_VALID = 7;
    localparam int XIRQ_BIT_SOFT0 = 2;
    localparam int XIRQ_BIT_CONV_DONE = 1;

    // Source indices, lowest index wins among equals
    localparam int XIRQ_NUM_SRC = 12;
    localparam int XIRQ_SRC_SERIAL = 0;
    localparam int XIRQ_SRC_CONV_WINDOW = 1;
    localparam int XIRQ_SRC_CMP_A_FALL = 2;
    localparam int XIRQ_SRC_CMP_A_RISE = 3;
    localparam int XIRQ_SRC_CMP_B_FALL = 4;
    localparam int XIRQ_SRC_CMP_B_RISE = 5;
    localparam int XIRQ_SRC_CONV_DONE = 6;
    localparam int XIRQ_SRC_SOFT0 = 7;
    localparam int XIRQ_NUM_SOFT = 4;
    localparam int XIRQ_SRC_CLOCK_VALID = 11;
    localparam int XIRQ_IDX_W = 4;

    // Service nesting state
    typedef enum logic [3:0] {
        XIRQ_SVC_NONE = 4'b0001,
        XIRQ_SVC_LOW = 4'b0010,
        XIRQ_SVC_HIGH = 4'b0100,
        XIRQ_SVC_NEST = 4'b1000
    } xirq_svc_e;
endpackage : xirq_pkg

// ===== verif/xirq_core_model.sv
`timescale 1ns/1ps
module xirq_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bench commands
    input wire logic take,
    input wire logic done,
    // Controller side
    input wire logic irq_valid,
    output logic irq_ack,
    output logic irq_return
);
    logic next_ack;
    logic next_return;
    // Ack only against a standing offer, so one take gives one pulse
    always_comb begin
        next_ack = take && irq_valid && !irq_ack;
        next_return = done && !irq_return;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_ack <= 1'h0;
            irq_return <= 1'h0;
        end else begin
            irq_ack <= next_ack;
            irq_return <= next_return;
        end
    end
endmodule : xirq_core_model

// ===== verif/xirq_ctrl_tb.sv
`timescale 1ns/1ps
module xirq_ctrl_tb;
    import xirq_pkg::*;
    logic clk, rst, sfr_wr, sfr_rd, take, done, gie, sfr_hit;
    logic irq_valid, irq_high, irq_ack, irq_return;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [XIRQ_NUM_SRC-1:0] src, gated_req, gated_level;
    logic [XIRQ_IDX_W-1:0] irq_index;
    int errors, comparisons;
    // Mask and level bit of each source index, in its register
    int bit_pos [12] = '{0, 2, 4, 5, 6, 7, 1, 2, 3, 4, 5, 7};

    xirq_ctrl #(.ADDR_W(8)) xirq_ctrl_inst (
        .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .global_irq_enable(gie), .cmp_b_rise_flag(src[5]), .cmp_b_fall_flag(src[4]),
        .cmp_a_rise_flag(src[3]), .cmp_a_fall_flag(src[2]), .conv_window_flag(src[1]),
        .serial_periph_flag(src[0]), .crystal_valid_flag(src[11]),
        .conv_done_flag(src[6]), .soft_irq_flag(src[10:7]), .gated_req(gated_req),
        .gated_level(gated_level), .irq_valid(irq_valid), .irq_index(irq_index),
        .irq_high(irq_high), .irq_ack(irq_ack), .irq_return(irq_return)
    );
    xirq_core_model xirq_core_model_inst (
        .clk(clk), .rst(rst), .take(take), .done(done), .irq_valid(irq_valid),
        .irq_ack(irq_ack), .irq_return(irq_return)
    );

    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input string name, input logic [11:0] exp, input logic [11:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_wr <= 1'h1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge clk);
        sfr_wr <= 1'h0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
        @(posedge clk);
        sfr_rd <= 1'h1;
        sfr_addr <= a;
        @(posedge clk);
        sfr_rd <= 1'h0;
        #1;
        check("sfr_rdata", exp, sfr_rdata);
        check("sfr_hit", hit, sfr_hit);
    endtask : rd

    // Output edge, then two spare edges
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    task automatic core(input logic ret);
        @(posedge clk);
        take <= !ret;
        done <= ret;
        @(posedge clk);
        take <= 1'h0;
        done <= 1'h0;
        repeat (3) @(posedge clk);
        #1;
    endtask : core

    task automatic offer(input logic v, input int idx, input logic hi);
        check("irq_valid", v, irq_valid);
        if (v) begin
            check("irq_index", idx, irq_index);
            check("irq_high", hi, irq_high);
        end
    endtask : offer

    task automatic test_regs;
        logic [7:0] addr [4];
        logic [7:0] keep [4];
        logic [7:0] wval [4];
        addr = '{XIRQ_ADDR_ENABLE_A, XIRQ_ADDR_ENABLE_B, XIRQ_ADDR_LEVEL_A, XIRQ_ADDR_LEVEL_B};
        keep = '{8'h00_F5, 8'h00_BE, 8'h00_F5, 8'h00_BE};
        // Software keeps bit 6 of the second pair at zero
        wval = '{8'h00_FF, 8'h00_BF, 8'h00_FF, 8'h00_BF};
        for (int i = 0; i < 4; i++) begin
            rd(addr[i], 8'h00_00, 1'h1);
            wr(addr[i], wval[i]);
            rd(addr[i], keep[i], 1'h1);
            wr(addr[i], 8'h00_00);
            rd(addr[i], 8'h00_00, 1'h1);
        end
        rd(8'h00_10, 8'h00_00, 1'h0);
        $display("test regs done");
    endtask : test_regs

    task automatic test_gating;
        logic [7:0] ea, eb;
        gie <= 1'h1;
        src <= '1;
        for (int i = 0; i < XIRQ_NUM_SRC; i++) begin
            ea = (i < 6) ? 8'(1 << bit_pos[i]) : 8'h00_00;
            eb = (i < 6) ? 8'h00_00 : 8'(1 << bit_pos[i]);
            wr(XIRQ_ADDR_ENABLE_A, ea);
            wr(XIRQ_ADDR_ENABLE_B, eb);
            wr(XIRQ_ADDR_LEVEL_A, ea);
            wr(XIRQ_ADDR_LEVEL_B, eb);
            settle();
            check("gated_req", 12'(1 << i), gated_req);
            check("gated_level", 12'(1 << i), gated_level);
            offer(1'h1, i, 1'h1);
        end
        wr(XIRQ_ADDR_ENABLE_A, 8'h00_FF);
        wr(XIRQ_ADDR_ENABLE_B, 8'h00_BF);
        settle();
        check("gated_req", '1, gated_req);
        src <= '0;
        settle();
        check("gated_req", '0, gated_req);
        src <= '1;
        gie <= 1'h0;
        settle();
        check("gated_req", '0, gated_req);
        offer(1'h0, 0, 1'h0);
        gie <= 1'h1;
        $display("test gating done");
    endtask : test_gating

    task automatic test_arb;
        wr(XIRQ_ADDR_LEVEL_A, 8'h00_00);
        wr(XIRQ_ADDR_LEVEL_B, 8'h00_80);
        settle();
        offer(1'h1, XIRQ_SRC_CLOCK_VALID, 1'h1);
        core(1'h0);
        repeat (4) @(posedge clk);
        #1;
        offer(1'h0, 0, 1'h0);
        core(1'h1);
        offer(1'h1, XIRQ_SRC_CLOCK_VALID, 1'h1);
        wr(XIRQ_ADDR_LEVEL_B, 8'h00_00);
        settle();
        offer(1'h1, XIRQ_SRC_SERIAL, 1'h0);
        src <= 12'(1 << XIRQ_SRC_SERIAL);
        core(1'h0);
        offer(1'h0, 0, 1'h0);
        wr(XIRQ_ADDR_LEVEL_A, 8'h00_80);
        src <= 12'((1 << XIRQ_SRC_SERIAL) | (1 << XIRQ_SRC_CMP_B_RISE));
        settle();
        offer(1'h1, XIRQ_SRC_CMP_B_RISE, 1'h1);
        core(1'h0);
        offer(1'h0, 0, 1'h0);
        core(1'h1);
        offer(1'h1, XIRQ_SRC_CMP_B_RISE, 1'h1);
        $display("test arbitration done");
    endtask : test_arb

    // Mid-run reset must drop nesting state and registers at once
    task automatic test_reset;
        @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        #1;
        offer(1'h0, 0, 1'h0);
        check("gated_level", '0, gated_level);
        rd(XIRQ_ADDR_ENABLE_A, 8'h00_00, 1'h1);
        rd(XIRQ_ADDR_LEVEL_A, 8'h00_00, 1'h1);
        check("gated_req", '0, gated_req);
        // A low offer shows the nesting state went back to idle
        wr(XIRQ_ADDR_ENABLE_A, 8'h00_80);
        settle();
        offer(1'h1, XIRQ_SRC_CMP_B_RISE, 1'h0);
        $display("test reset done");
    endtask : test_reset

    task automatic complete_run;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        rst = 1'h1;
        sfr_wr = 1'h0;
        sfr_rd = 1'h0;
        sfr_addr = 8'h00_00;
        sfr_wdata = 8'h00_00;
        take = 1'h0;
        done = 1'h0;
        gie = 1'h0;
        src = '0;
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        test_regs();
        test_gating();
        test_arb();
        test_reset();
        complete_run();
    end

    // Whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        complete_run();
    end
endmodule : xirq_ctrl_tb
